/* File: i2c_register_slave.sv */
// Two-wire serial register slave with sixteen eight-bit registers.
//
// Operation
// R01: Answer only to seven-bit bus address 0x1A.
// R02: Sixteen eight-bit registers at indices 0x00 to 0x0F.
// R03: Reads above index 0x0F return 0xFF.
// R04: Works at bit rates up to 100 and 400 kbit/s.
// R05: Data line is open drain; pulled low, never driven high.
// R06: Start is SDA falling with SCL high; stop is SDA rising.
// R07: Bus busy from a start until the next stop.
// R08: SDA changes only while SCL low; one SCL pulse per bit.
// R09: Every byte is eight bits, most significant bit first.
// R10: Ninth pulse carries acknowledge; receiver pulls SDA low to accept.
// R11: Master makes all clock pulses, starts and stops; SCL never driven.
// R12: First byte after start is address plus direction bit, 1 reads.
// R13: Direction fixed per transaction; repeated start changes it.
// R14: First byte after a write address sets the register pointer.
// R15: Written data bytes fill the pointed register, then pointer increments.
// R16: Read returns pointed register; master ack requests next, nack ends.
// R17: Master closes every transaction with a stop.
// R18: Any number of data bytes per transaction. Writes end with a not-acknowledge while the two-entry buffer is full.
// R19: Registers are eight bits, bit 0 least significant.
// R20: Mismatched address gets no acknowledge; transaction ignored.
// R21: Pointer increments after every byte sent in a read.
// R22: Writes past the last register are acknowledged but stored nowhere.
`timescale 1ns/1ps

module i2c_register_slave
  import i2c_register_slave_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  output logic bus_busy_o,
  output logic wr_valid_o,
  output logic [REG_AW-1:0] wr_addr_o,
  output logic [DATA_W-1:0] wr_data_o,
  input wire logic wr_ready_i
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and glitch filter.

  logic [SYNC_STAGES-1:0] scl_sync_r;
  logic [SYNC_STAGES-1:0] sda_sync_r;
  logic scl_r;
  logic sda_r;
  logic scl_prev_r;
  logic sda_prev_r;

  // The first stage is only read by the second; a level is accepted once
  // the second and third stages agree, which rejects single-cycle spikes.
  // About five clocks from pin to action still fit inside a fast-mode low phase. [R04]
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      scl_sync_r <= '1;
      sda_sync_r <= '1;
    end
    else
    begin
      scl_sync_r <= {scl_sync_r[SYNC_STAGES-2:0], scl_i};
      sda_sync_r <= {sda_sync_r[SYNC_STAGES-2:0], sda_i};
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      scl_r <= 1'b1;
      sda_r <= 1'b1;
      scl_prev_r <= 1'b1;
      sda_prev_r <= 1'b1;
    end
    else
    begin
      if (scl_sync_r[1] == scl_sync_r[2])
      begin
        scl_r <= scl_sync_r[2];
      end
      if (sda_sync_r[1] == sda_sync_r[2])
      begin
        sda_r <= sda_sync_r[2];
      end
      scl_prev_r <= scl_r;
      sda_prev_r <= sda_r;
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;

  // Edges of SDA count as start or stop only while SCL stays high.
  assign scl_rise = scl_r & ~scl_prev_r; // [R08]
  assign scl_fall = ~scl_r & scl_prev_r; // [R08]
  assign start_det = scl_r & scl_prev_r & sda_prev_r & ~sda_r; // [R06]
  assign stop_det = scl_r & scl_prev_r & ~sda_prev_r & sda_r; // [R06]

  ////////////////////////////////////////////////////////////////////////////
  // Register file and two-entry write buffer.

  logic [DATA_W-1:0] regs_r [REG_COUNT];
  logic [BUF_W-1:0] buf_r [BUF_DEPTH];
  logic [1:0] buf_cnt_r;
  logic buf_push;
  logic buf_pop;
  logic buf_ready;
  logic [BUF_W-1:0] push_word;

  assign buf_ready = (buf_cnt_r != 2'(BUF_DEPTH));
  assign buf_pop = wr_valid_o & wr_ready_i;

  // The serial side cannot be stalled because the slave never holds SCL,
  // so a full buffer is answered with a not-acknowledge instead.
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      buf_cnt_r <= 2'h0;
      for (int i = 0; i < BUF_DEPTH; i++)
      begin
        buf_r[i] <= '0;
      end
    end
    else
    begin
      if (buf_pop)
      begin
        buf_r[0] <= buf_r[1];
      end
      // A push together with a pop can only meet a single held word.
      if (buf_push)
      begin
        buf_r[buf_cnt_r[0] & ~buf_pop] <= push_word;
      end
      buf_cnt_r <= buf_cnt_r + {1'b0, buf_push} - {1'b0, buf_pop};
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      wr_valid_o <= 1'b0;
      wr_addr_o <= '0;
      wr_data_o <= '0;
    end
    else
    begin
      // Head of the buffer as seen after this cycle's push and pop.
      if (buf_pop)
      begin
        wr_valid_o <= (buf_cnt_r == 2'h2) | buf_push;
        wr_addr_o <= (buf_cnt_r == 2'h2) ? buf_r[1][BUF_W-1:DATA_W]
                                         : push_word[BUF_W-1:DATA_W];
        wr_data_o <= (buf_cnt_r == 2'h2) ? buf_r[1][DATA_W-1:0]
                                         : push_word[DATA_W-1:0];
      end
      else if (buf_cnt_r == 2'h0)
      begin
        wr_valid_o <= buf_push;
        wr_addr_o <= push_word[BUF_W-1:DATA_W];
        wr_data_o <= push_word[DATA_W-1:0];
      end
    end
  end

  // A register takes its byte when the consumer accepts the write.
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      for (int i = 0; i < REG_COUNT; i++)
      begin
        regs_r[i] <= REG_RESET_VAL; // [R02] [R19]
      end
    end
    else if (buf_pop)
    begin
      regs_r[wr_addr_o] <= wr_data_o; // [R15]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Serial link state machine.

  link_state_t state_r;
  logic [3:0] bit_cnt_r;
  logic [7:0] shift_r;
  logic [7:0] ptr_r;
  logic read_r;
  logic ptr_phase_r;
  logic ack_ok_r;

  // Indices past the last register read as all ones.
  function automatic logic [7:0] read_byte(input logic [7:0] ptr);
    read_byte = (ptr > LAST_REG) ? READ_FILL : regs_r[ptr[REG_AW-1:0]]; // [R02] [R03]
  endfunction

  logic in_range;
  logic data_byte_done;
  logic [7:0] next_byte;

  always_comb
  begin
    next_byte = read_byte(ptr_r);
  end

  assign in_range = (ptr_r <= LAST_REG);
  assign data_byte_done = (state_r == ST_WRITE) && scl_fall && (bit_cnt_r == BITS_PER_BYTE);
  assign push_word = {ptr_r[REG_AW-1:0], shift_r};
  // Out-of-range data is acknowledged and dropped.
  assign buf_push = data_byte_done && !ptr_phase_r && in_range && buf_ready; // [R15] [R22]

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      bus_busy_o <= 1'b0;
    end
    else if (start_det)
    begin
      bus_busy_o <= 1'b1; // [R07]
    end
    else if (stop_det)
    begin
      bus_busy_o <= 1'b0; // [R07]
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      state_r <= ST_IDLE;
      bit_cnt_r <= 4'h0;
      shift_r <= 8'h00;
      ptr_r <= PTR_RESET_VAL;
      read_r <= 1'b0;
      ptr_phase_r <= 1'b0;
      ack_ok_r <= 1'b0;
      sda_oe_o <= 1'b0;
    end
    else if (start_det)
    begin
      // A repeated start is allowed anywhere and reopens address phase.
      state_r <= ST_ADDR; // [R12] [R13]
      bit_cnt_r <= 4'h0;
      sda_oe_o <= 1'b0;
    end
    else if (stop_det)
    begin
      state_r <= ST_IDLE; // [R17]
      sda_oe_o <= 1'b0;
    end
    else
    begin
      unique case (state_r)
        ST_IDLE:
        begin
          sda_oe_o <= 1'b0;
        end
        ST_ADDR, ST_WRITE:
        begin
          if (scl_rise && bit_cnt_r != BITS_PER_BYTE)
          begin
            shift_r <= {shift_r[6:0], sda_r}; // [R09]
            bit_cnt_r <= bit_cnt_r + 4'h1;
          end
          else if (scl_fall && bit_cnt_r == BITS_PER_BYTE)
          begin
            bit_cnt_r <= 4'h0;
            if (state_r == ST_ADDR)
            begin
              if (shift_r[7:1] == SLAVE_ADDR) // [R01]
              begin
                read_r <= shift_r[0]; // [R12]
                ptr_phase_r <= ~shift_r[0]; // [R14]
                sda_oe_o <= 1'b1; // [R10]
                state_r <= ST_ACK;
              end
              else
              begin
                state_r <= ST_IDLE; // [R20]
              end
            end
            else if (ptr_phase_r)
            begin
              ptr_r <= shift_r; // [R14]
              ptr_phase_r <= 1'b0;
              sda_oe_o <= 1'b1; // [R10]
              state_r <= ST_ACK;
            end
            else if (!in_range || buf_ready)
            begin
              ptr_r <= ptr_r + 8'h01; // [R15] [R18]
              sda_oe_o <= 1'b1; // [R10]
              state_r <= ST_ACK;
            end
            else
            begin
              // Buffer full: not-acknowledge and keep the pointer.
              state_r <= ST_IDLE;
            end
          end
        end
        ST_ACK, ST_MACK:
        begin
          if (scl_rise && state_r == ST_MACK)
          begin
            ack_ok_r <= ~sda_r; // [R16]
          end
          else if (scl_fall)
          begin
            if (read_r && (state_r == ST_ACK || ack_ok_r))
            begin
              shift_r <= next_byte; // [R16] [R18]
              ptr_r <= ptr_r + 8'h01; // [R21]
              sda_oe_o <= ~next_byte[7]; // [R05] [R09]
              bit_cnt_r <= 4'h0;
              state_r <= ST_READ; // [R13]
            end
            else
            begin
              sda_oe_o <= 1'b0;
              state_r <= read_r ? ST_IDLE : ST_WRITE; // [R13] [R16]
            end
          end
        end
        ST_READ:
        begin
          if (scl_fall)
          begin
            if (bit_cnt_r == LAST_TX_BIT)
            begin
              sda_oe_o <= 1'b0; // [R10]
              state_r <= ST_MACK;
            end
            else
            begin
              shift_r <= {shift_r[6:0], 1'b0};
              sda_oe_o <= ~shift_r[6]; // [R05] [R08] [R09]
              bit_cnt_r <= bit_cnt_r + 4'h1;
            end
          end
        end
      endcase
    end
  end

  // The line is only ever pulled low; the enable alone carries the data.
  always_ff @(posedge sys_clk_i)
  begin
    sda_o <= 1'b0; // [R05] [R11]
  end

endmodule // i2c_register_slave

/* File: i2c_register_slave_pkg.sv */
// Constants and types shared by the two-wire register slave.
package i2c_register_slave_pkg;

  // Seven-bit bus address the slave answers to.
  localparam logic [6:0] SLAVE_ADDR = 7'h1a;

  // Register file shape: sixteen eight-bit registers.
  localparam int REG_COUNT = 16;
  localparam int REG_AW = 4;
  localparam int DATA_W = 8;
  localparam logic [7:0] LAST_REG = 8'h0f;
  localparam logic [7:0] READ_FILL = 8'hff;
  localparam logic [7:0] REG_RESET_VAL = 8'h00;
  localparam logic [7:0] PTR_RESET_VAL = 8'h00;

  // Bit counter positions within one byte.
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] LAST_TX_BIT = 4'h7;

  // Write buffer between the serial side and the register file.
  localparam int BUF_DEPTH = 2;
  localparam int BUF_W = REG_AW + DATA_W;

  // Clock and bus timing.
  localparam int SYS_CLK_HZ = 40_000_000;
  localparam int STD_RATE_BPS = 100_000;
  localparam int FAST_RATE_BPS = 400_000;
  // Shortest SCL period in system clocks (fastest rate, rounded down).
  localparam int FAST_BIT_CYCLES = SYS_CLK_HZ / FAST_RATE_BPS;
  localparam int STD_BIT_CYCLES = SYS_CLK_HZ / STD_RATE_BPS;
  // Pin synchroniser depth.
  localparam int SYNC_STAGES = 3;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ACK,
    ST_WRITE,
    ST_READ,
    ST_MACK
  } link_state_t;

endpackage

/* File: i2c_register_slave_sva.sv */
// Port-level checks for the two-wire register slave.
`timescale 1ns/1ps
module i2c_register_slave_sva
  import i2c_register_slave_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe_o,
  input wire logic bus_busy_o,
  input wire logic wr_valid_o,
  input wire logic [REG_AW-1:0] wr_addr_o,
  input wire logic [DATA_W-1:0] wr_data_o,
  input wire logic wr_ready_i
);
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (rst_i);

  AST_RESET_QUIET: assert property ($past(rst_i) |->
    !bus_busy_o && !wr_valid_o && !sda_oe_o)
    else $error("outputs active right after reset");
  AST_OPEN_DRAIN: assert property (!sda_o)
    else $error("data pin value not low");
  AST_START_BUSY: assert property ($fell(sda_i) && scl_i |-> ##[1:10] bus_busy_o)
    else $error("start not seen");
  AST_STOP_FREE: assert property ($rose(sda_i) && scl_i |-> ##[1:10] !bus_busy_o)
    else $error("stop not seen");
  AST_OE_SCL_LOW: assert property ($changed(sda_oe_o) |-> !scl_i)
    else $error("data drive changed while clock high");
  AST_IDLE_RELEASED: assert property (!bus_busy_o |-> !sda_oe_o)
    else $error("data pulled while bus free");
  AST_WORD_HOLD: assert property (wr_valid_o && !wr_ready_i |=>
    wr_valid_o && $stable(wr_addr_o) && $stable(wr_data_o))
    else $error("pending word changed before taken");
  AST_PUSH_IN_FRAME: assert property ($rose(wr_valid_o) |-> bus_busy_o)
    else $error("word appeared outside a transfer");
endmodule // i2c_register_slave_sva

bind i2c_register_slave i2c_register_slave_sva i2c_register_slave_sva_inst (
  .sys_clk_i(sys_clk_i), .rst_i(rst_i), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o),
  .sda_oe_o(sda_oe_o), .bus_busy_o(bus_busy_o), .wr_valid_o(wr_valid_o),
  .wr_addr_o(wr_addr_o), .wr_data_o(wr_data_o), .wr_ready_i(wr_ready_i)
);

/* File: link_master.sv */
// Behavioural bus master driving the two-wire link.
`timescale 1ns/1ps
module link_master
(
  output logic scl_o,
  output logic sda_o,
  input wire logic sda_i
);
  // Quarter of a 400 kbit/s bit, so the slave's filtered reaction lands while SCL is low.
  localparam int QTR = 625;
  initial
  begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  task automatic start();
    sda_o = 1'b1;
    #QTR scl_o = 1'b1;
    #QTR sda_o = 1'b0;
    #QTR scl_o = 1'b0;
    #QTR;
  endtask
  task automatic stop();
    sda_o = 1'b0;
    #QTR scl_o = 1'b1;
    #QTR sda_o = 1'b1;
    #QTR;
  endtask
  task automatic bit_io(input logic b, output logic r);
    sda_o = b;
    #QTR scl_o = 1'b1;
    #QTR r = sda_i;
    #QTR scl_o = 1'b0;
    #QTR;
  endtask
  task automatic xfer(input logic [7:0] d, input logic ack_in, output logic [7:0] q,
                      output logic ack_seen);
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(d[i], q[i]);
    end
    bit_io(ack_in, ack_seen);
  endtask
endmodule // link_master

/* File: tb_top.sv */
// Self-checking bench for the two-wire register slave.
`timescale 1ns/1ps
module tb_top
  import i2c_register_slave_pkg::*;
;
  localparam logic ACK = 1'b0;
  localparam logic NACK = 1'b1;
  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wr_ready_i = 1'b1;
  logic scl, sda_m, sda_oe, sda_val, busy, wr_valid, sda_wire;
  logic [REG_AW-1:0] wr_addr;
  logic [DATA_W-1:0] wr_data;
  int n_mismatch = 0;
  int cmp_count = 0;
  logic [11:0] wq[$];
  // Pull-up: the line reads high unless someone pulls it, even before reset settles.
  assign sda_wire = (sda_m === 1'b0 || sda_oe === 1'b1) ? 1'b0 : 1'b1;
  always #12.5 sys_clk_i = ~sys_clk_i;
  link_master link_master_inst (.scl_o(scl), .sda_o(sda_m), .sda_i(sda_wire));
  i2c_register_slave i2c_register_slave_inst (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
    .scl_i(scl), .sda_i(sda_wire), .sda_o(sda_val), .sda_oe_o(sda_oe), .bus_busy_o(busy),
    .wr_valid_o(wr_valid), .wr_addr_o(wr_addr), .wr_data_o(wr_data), .wr_ready_i(wr_ready_i));
  always @(posedge sys_clk_i)
  begin
    if (wr_valid === 1'b1 && wr_ready_i === 1'b1)
    begin
      wq.push_back({wr_addr, wr_data});
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [11:0] seen, input logic [11:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic end_of_test();
    $display("Comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
    begin
      $display("Simulation passed");
    end
    else
    begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Waits for the bus to go free and k words to be taken.
  task automatic settle(input int k);
    int n;
    n = 0;
    while ((busy !== 1'b0 || wq.size() < k) && n < 300)
    begin
      @(posedge sys_clk_i);
      n++;
    end
    if (n == 300)
    begin
      n_mismatch++;
      end_of_test();
    end
    #1;
  endtask
  task automatic put(input logic [7:0] d, input logic ack_exp);
    logic [7:0] q;
    logic a;
    link_master_inst.xfer(d, NACK, q, a);
    check("ack", {11'h0, a}, {11'h0, ack_exp});
  endtask
  task automatic get(input logic [7:0] exp, input logic last);
    logic [7:0] q;
    logic a;
    link_master_inst.xfer(8'hff, last, q, a);
    check("read", {4'h0, q}, {4'h0, exp});
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic s_write();
    wq = {};
    link_master_inst.start();
    check("busy", {11'h0, busy}, 12'h001);
    put(8'h34, ACK);
    put(8'h0e, ACK);
    put(8'ha5, ACK);
    put(8'h5a, ACK);
    put(8'hc3, ACK);
    link_master_inst.stop();
    settle(2);
    check("busy", {11'h0, busy}, 12'h000);
    check("word", wq.pop_front(), 12'hea5);
    check("word", wq.pop_front(), 12'hf5a);
    check("extra", 12'(wq.size()), 12'h000);
  endtask
  task automatic s_read();
    link_master_inst.start();
    put(8'h34, ACK);
    put(8'h0e, ACK);
    link_master_inst.start();
    put(8'h35, ACK);
    get(8'ha5, ACK);
    get(8'h5a, ACK);
    get(8'hff, NACK);
    check("sda_level", {11'h0, sda_val}, 12'h000);
    link_master_inst.stop();
    settle(0);
  endtask
  task automatic s_foreign();
    wq = {};
    link_master_inst.start();
    put(8'h36, NACK);
    put(8'h00, NACK);
    link_master_inst.stop();
    settle(0);
    check("extra", 12'(wq.size()), 12'h000);
  endtask
  // A stalled consumer fills the buffer; the third byte must be refused, not lost.
  task automatic s_stall();
    wq = {};
    @(posedge sys_clk_i);
    #1 wr_ready_i = 1'b0;
    link_master_inst.start();
    put(8'h34, ACK);
    put(8'h00, ACK);
    put(8'h81, ACK);
    put(8'h42, ACK);
    put(8'h99, NACK);
    link_master_inst.stop();
    settle(0);
    check("head_valid", {11'h0, wr_valid}, 12'h001);
    check("head_word", {wr_addr, wr_data}, 12'h081);
    @(posedge sys_clk_i);
    #1 wr_ready_i = 1'b1;
    settle(2);
    check("word", wq.pop_front(), 12'h081);
    check("word", wq.pop_front(), 12'h142);
    link_master_inst.start();
    put(8'h34, ACK);
    put(8'h00, ACK);
    link_master_inst.start();
    put(8'h35, ACK);
    get(8'h81, ACK);
    get(8'h42, ACK);
    get(8'h00, NACK);
    link_master_inst.stop();
    settle(0);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (5) @(posedge sys_clk_i);
    #1 rst_i = 1'b0;
    repeat (10) @(posedge sys_clk_i);
    #1;
    s_write();
    s_read();
    s_foreign();
    s_stall();
    end_of_test();
  end
  initial
  begin
    repeat (90000) @(posedge sys_clk_i);
    n_mismatch++;
    end_of_test();
  end
endmodule // tb_top
